// ===== logic/cplc_map.vh
/*
 * constants for the clock path and loopback controller: mode codes, clock source
 * and rate codes, field widths of a path selection word and timing counts.
 * assumes the includer runs on the 20 MHz system clock.
 */
`ifndef CPLC_MAP_VH
`define CPLC_MAP_VH

// ************************************************************
// system clock and timing
// ************************************************************
`define CPLC_CLK_PERIOD_NS 50
`define CPLC_SWITCH_GAP_NS 200
// 200 ns rounded up to whole cycles, sized for the gap counter
`define CPLC_SWITCH_GAP_CYC 4'h4
`define CPLC_GAP_CNT_W 4

// ************************************************************
// parallel interface modes and speeds
// ************************************************************
`define CPLC_MODE_GMII 2'h0
`define CPLC_MODE_RGMII 2'h1
`define CPLC_MODE_MII 2'h2
`define CPLC_SPEED_10 2'h0
`define CPLC_SPEED_100 2'h1
`define CPLC_SPEED_1000 2'h2

// ************************************************************
// clock sources and rates of one path
// ************************************************************
`define CPLC_SRC_NONE 3'h0
`define CPLC_SRC_GTX 3'h1
`define CPLC_SRC_TX_PLL 3'h2
`define CPLC_SRC_RX_PLL 3'h3
`define CPLC_SRC_TXCLK_PIN 3'h4
`define CPLC_SRC_RXCLK_PIN 3'h5
`define CPLC_RATE_2M5 2'h0
`define CPLC_RATE_25M 2'h1
`define CPLC_RATE_62M5 2'h2
`define CPLC_RATE_125M 2'h3
// one path word is {source, rate}
`define CPLC_PATH_W 5
`define CPLC_NUM_PATHS 5
`define CPLC_SEL_W 25

// ************************************************************
// gpio clock outputs
// ************************************************************
`define CPLC_NUM_GPIO 4
`define CPLC_GPIO_OFF 2'h0
`define CPLC_GPIO_REF_125 2'h1
`define CPLC_GPIO_REC_25 2'h2
`define CPLC_GPIO_REC_125 2'h3

`endif

// ===== logic/cplc_sel_switch.v
/*
 * break-before-make sequencer for the clock multiplexer selections.
 * assumes the requested selection word is synchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cplc_map.vh"

module cplc_sel_switch
(
   input wire clk_in,
   input wire rst_n_in,
   input wire [`CPLC_SEL_W-1:0] req_sel_in,
   output reg [`CPLC_SEL_W-1:0] sel_out,
   output reg gated_out
);

   // ************************************************************
   // state
   // ************************************************************
   localparam ST_RUN = 3'h1;
   localparam ST_GAP = 3'h2;
   localparam ST_LOAD = 3'h4;
   localparam [`CPLC_GAP_CNT_W-1:0] GAP_CYC = `CPLC_SWITCH_GAP_CYC;

   reg [2:0] state;
   reg [`CPLC_GAP_CNT_W-1:0] gap_cnt;
   reg [`CPLC_SEL_W-1:0] held_sel;

   // all paths stop before any restarts: a runt pulse cannot reach a buffer
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state <= ST_RUN;
         gap_cnt <= 4'h0;
         held_sel <= 25'h0;
         sel_out <= 25'h0;
         gated_out <= 1'b1;
      end
      else
      begin
         case (state)
            ST_RUN:
            begin
               if (req_sel_in != held_sel)
               begin
                  state <= ST_GAP;
                  sel_out <= 25'h0;
                  gated_out <= 1'b1;
                  gap_cnt <= GAP_CYC;
               end
               else
               begin
                  gated_out <= 1'b0;
               end
            end
            ST_GAP:
            begin
               if (gap_cnt <= 4'h1)
               begin
                  state <= ST_LOAD;
               end
               gap_cnt <= gap_cnt - 4'h1;
            end
            ST_LOAD:
            begin
               // a request that changed again during the gap is taken here
               held_sel <= req_sel_in;
               sel_out <= req_sel_in;
               gated_out <= 1'b0;
               state <= ST_RUN;
            end
            default:
            begin
               state <= ST_RUN;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ===== logic/cplc_gpio_clk.v
/*
 * one gpio clock output: picks a clock level, switches and squelches only
 * while the output is low. assumes the source levels are synchronous samples.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cplc_map.vh"

module cplc_gpio_clk
(
   input wire clk_in,
   input wire rst_n_in,
   input wire [1:0] src_sel_in,
   input wire squelch_in,
   input wire ref_125_in,
   input wire rec_25_in,
   input wire rec_125_in,
   output reg clk_out
);

   reg [1:0] cur_src;
   reg cur_level;
   reg target_level;
   wire [1:0] target;

   assign target = squelch_in ? `CPLC_GPIO_OFF : src_sel_in;

   always @*
   begin
      case (cur_src)
         `CPLC_GPIO_REF_125: cur_level = ref_125_in;
         `CPLC_GPIO_REC_25: cur_level = rec_25_in;
         `CPLC_GPIO_REC_125: cur_level = rec_125_in;
         default: cur_level = 1'b0;
      endcase
      case (target)
         `CPLC_GPIO_REF_125: target_level = ref_125_in;
         `CPLC_GPIO_REC_25: target_level = rec_25_in;
         `CPLC_GPIO_REC_125: target_level = rec_125_in;
         default: target_level = 1'b0;
      endcase
   end

   // a high phase is never cut short, and a new source starts on its own low
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cur_src <= `CPLC_GPIO_OFF;
         clk_out <= 1'b0;
      end
      else if ((target != cur_src) && !clk_out && !target_level)
      begin
         cur_src <= target;
         clk_out <= 1'b0;
      end
      else
      begin
         clk_out <= cur_level;
      end
   end

endmodule
`default_nettype wire

// ===== logic/cplc_top.v
/*
 * clock path and loopback controller of the parallel-to-serial converter.
 * assumes all inputs, including sampled clock levels, are synchronous to CLK_IN,
 * and that the analog plls and multiplexers act on the selection words.
 */

// Operation
// - tx buffer clock: gtx, tx pll or pin
// - rx pcs on rx pll; buffer per mode
// - diagnostic loopback moves rx clocks to tx
// - remote loopback clocks tx buffer from rx
// - latch rx pll loss of lock
// - reference frequency from two strap pins
// - tx pll feeds eight-phase timing clock
// - gpio may carry tx pll 125 clock
// - gpio may carry recovered 25/125 clock
// - gpio clocks never glitch
// - diagnostic loopback: decoder takes encoder codes
// - diagnostic drive-out bit gates serial driver
// - collision low in diagnostic unless test
// - terminal loopback: cdr takes driver data
// - terminal drive-out bit gates serial driver
// - remote loopback: tx takes rx data
// - remote drive-out bit zeroes rx pins
// - link down squelches recovered gpio clocks
`timescale 1ns/1ps
`default_nettype none
`include "cplc_map.vh"

module cplc_top
(
   input wire CLK_IN,
   input wire RST_N_IN,
   input wire [1:0] IF_MODE_IN,
   input wire [1:0] LINK_SPEED_IN,
   input wire MII_DCE_IN,
   input wire DIAG_LOOP_ENABLE_IN,
   input wire DIAG_LOOP_DRIVE_OUT_IN,
   input wire TERMINAL_LOOP_ENABLE_IN,
   input wire TERMINAL_LOOP_DRIVE_OUT_IN,
   input wire REMOTE_LOOP_ENABLE_IN,
   input wire REMOTE_LOOP_DRIVE_OUT_IN,
   input wire COLLISION_TEST_ENABLE_IN,
   input wire SERIAL_TX_CLOCK_ENABLE_IN,
   input wire RX_PLL_LOCK_LOST_IN,
   input wire LOCK_LOST_CLEAR_IN,
   input wire [1:0] REF_STRAP_IN,
   input wire AN_LINK_GOOD_IN,
   input wire RECOVERED_CLOCK_SQUELCH_ENABLE_IN,
   input wire [7:0] GPIO_CLK_SRC_IN,
   input wire TX_PLL_125_LEVEL_IN,
   input wire RX_PLL_25_LEVEL_IN,
   input wire RX_PLL_125_LEVEL_IN,
   input wire [7:0] RX_DATA_IN,
   input wire RX_DV_IN,
   input wire RX_ER_IN,
   input wire CRS_IN,
   input wire COL_IN,
   input wire TX_EN_IN,
   output wire [2:0] TX_BUF_CLK_SRC_OUT,
   output wire [1:0] TX_BUF_CLK_RATE_OUT,
   output wire [2:0] TXCLK_DRV_SRC_OUT,
   output wire [1:0] TXCLK_DRV_RATE_OUT,
   output wire [2:0] RX_PCS_CLK_SRC_OUT,
   output wire [1:0] RX_PCS_CLK_RATE_OUT,
   output wire [2:0] RX_BUF_CLK_SRC_OUT,
   output wire [1:0] RX_BUF_CLK_RATE_OUT,
   output wire [2:0] RXCLK_DRV_SRC_OUT,
   output wire [1:0] RXCLK_DRV_RATE_OUT,
   output wire CLOCKS_GATED_OUT,
   output reg RX_DEC_FROM_ENCODER_OUT,
   output reg CDR_FROM_TX_DRIVER_OUT,
   output reg TX_DATA_FROM_RX_OUT,
   output reg SERIAL_TX_PAIR_OE_OUT,
   output reg SERIAL_TX_CLOCK_OUT_EN_OUT,
   output reg RX_PLL_LOCK_LOST_LATCHED_OUT,
   output reg [1:0] REF_FREQ_SEL_OUT,
   output reg REF_FREQ_VALID_OUT,
   output reg PHASE_CLK_ENABLE_OUT,
   output wire [3:0] GPIO_CLK_OUT,
   output reg [7:0] RXD_OUT,
   output reg RX_DV_OUT,
   output reg RX_ER_OUT,
   output reg CRS_OUT,
   output reg COL_OUT
);

   // ************************************************************
   // mode decode
   // ************************************************************
   wire is_mii;
   wire mii_dce;
   wire mii_dte;
   reg [1:0] mode_rate;
   wire diag;
   wire term;
   wire remote;

   assign is_mii = (IF_MODE_IN == `CPLC_MODE_MII);
   assign mii_dce = is_mii & MII_DCE_IN;
   assign mii_dte = is_mii & ~MII_DCE_IN;
   assign diag = DIAG_LOOP_ENABLE_IN;
   assign term = TERMINAL_LOOP_ENABLE_IN;
   // remote loopback relies on software keeping the other two clear
   assign remote = REMOTE_LOOP_ENABLE_IN;

   // the parallel clock rate; gmii always runs at 125
   always @*
   begin
      if (IF_MODE_IN == `CPLC_MODE_GMII)
      begin
         mode_rate = `CPLC_RATE_125M;
      end
      else
      begin
         case (LINK_SPEED_IN)
            `CPLC_SPEED_10: mode_rate = `CPLC_RATE_2M5;
            `CPLC_SPEED_100: mode_rate = `CPLC_RATE_25M;
            `CPLC_SPEED_1000: mode_rate = `CPLC_RATE_125M;
            default: mode_rate = `CPLC_RATE_25M;
         endcase
      end
   end

   // ************************************************************
   // clock path selection
   // ************************************************************
   reg [2:0] tx_buf_src;
   reg [2:0] txclk_src;
   reg [2:0] rx_pcs_src;
   reg [2:0] rx_buf_src;
   reg [2:0] rxclk_src;
   wire [`CPLC_SEL_W-1:0] req_sel;
   wire [`CPLC_SEL_W-1:0] cur_sel;

   always @*
   begin
      // transmit rate buffer
      if (remote)
      begin
         tx_buf_src = mii_dte ? `CPLC_SRC_RXCLK_PIN : `CPLC_SRC_RX_PLL;
      end
      else if (mii_dce)
      begin
         tx_buf_src = `CPLC_SRC_TX_PLL;
      end
      else if (mii_dte)
      begin
         tx_buf_src = `CPLC_SRC_TXCLK_PIN;
      end
      else
      begin
         tx_buf_src = `CPLC_SRC_GTX;
      end
      // driven transmit clock exists in dce mode only, also under remote loopback
      txclk_src = mii_dce ? `CPLC_SRC_TX_PLL : `CPLC_SRC_NONE;
      // receive pcs
      rx_pcs_src = diag ? `CPLC_SRC_TX_PLL : `CPLC_SRC_RX_PLL;
      // receive rate buffer and driven receive clock
      if (mii_dte)
      begin
         rx_buf_src = diag ? `CPLC_SRC_TXCLK_PIN : `CPLC_SRC_RXCLK_PIN;
         rxclk_src = `CPLC_SRC_NONE;
      end
      else
      begin
         rx_buf_src = diag ? `CPLC_SRC_TX_PLL : `CPLC_SRC_RX_PLL;
         rxclk_src = diag ? `CPLC_SRC_TX_PLL : `CPLC_SRC_RX_PLL;
      end
   end

   assign req_sel = {tx_buf_src, mode_rate,
                     txclk_src, (mii_dce ? mode_rate : `CPLC_RATE_2M5),
                     rx_pcs_src, `CPLC_RATE_62M5,
                     rx_buf_src, mode_rate,
                     rxclk_src, (mii_dte ? `CPLC_RATE_2M5 : mode_rate)};

   cplc_sel_switch u_switch
   (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .req_sel_in(req_sel),
      .sel_out(cur_sel),
      .gated_out(CLOCKS_GATED_OUT)
   );

   assign {TX_BUF_CLK_SRC_OUT, TX_BUF_CLK_RATE_OUT} = cur_sel[24:20];
   assign {TXCLK_DRV_SRC_OUT, TXCLK_DRV_RATE_OUT} = cur_sel[19:15];
   assign {RX_PCS_CLK_SRC_OUT, RX_PCS_CLK_RATE_OUT} = cur_sel[14:10];
   assign {RX_BUF_CLK_SRC_OUT, RX_BUF_CLK_RATE_OUT} = cur_sel[9:5];
   assign {RXCLK_DRV_SRC_OUT, RXCLK_DRV_RATE_OUT} = cur_sel[4:0];

   // ************************************************************
   // loopback data steering and serial driver
   // ************************************************************
   wire tx_pair_off;

   // either serial loopback without its drive-out bit floats the driver
   assign tx_pair_off = (diag & ~DIAG_LOOP_DRIVE_OUT_IN) | (term & ~TERMINAL_LOOP_DRIVE_OUT_IN);

   always @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         RX_DEC_FROM_ENCODER_OUT <= 1'b0;
         CDR_FROM_TX_DRIVER_OUT <= 1'b0;
         TX_DATA_FROM_RX_OUT <= 1'b0;
         SERIAL_TX_PAIR_OE_OUT <= 1'b0;
         SERIAL_TX_CLOCK_OUT_EN_OUT <= 1'b0;
      end
      else
      begin
         RX_DEC_FROM_ENCODER_OUT <= diag;
         CDR_FROM_TX_DRIVER_OUT <= term;
         TX_DATA_FROM_RX_OUT <= remote;
         SERIAL_TX_PAIR_OE_OUT <= ~tx_pair_off;
         // the serial clock keeps toggling through any loopback
         SERIAL_TX_CLOCK_OUT_EN_OUT <= SERIAL_TX_CLOCK_ENABLE_IN;
      end
   end

   // ************************************************************
   // receive parallel pins
   // ************************************************************
   wire rx_pins_low;

   assign rx_pins_low = remote & ~REMOTE_LOOP_DRIVE_OUT_IN;

   always @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         RXD_OUT <= 8'h00;
         RX_DV_OUT <= 1'b0;
         RX_ER_OUT <= 1'b0;
         CRS_OUT <= 1'b0;
         COL_OUT <= 1'b0;
      end
      else
      begin
         if (rx_pins_low)
         begin
            RXD_OUT <= 8'h00;
            RX_DV_OUT <= 1'b0;
            RX_ER_OUT <= 1'b0;
            CRS_OUT <= 1'b0;
         end
         else
         begin
            RXD_OUT <= RX_DATA_IN;
            RX_DV_OUT <= RX_DV_IN;
            RX_ER_OUT <= RX_ER_IN;
            CRS_OUT <= CRS_IN;
         end
         // collision test: collision follows transmit enable
         if (diag)
         begin
            COL_OUT <= COLLISION_TEST_ENABLE_IN & TX_EN_IN;
         end
         else
         begin
            COL_OUT <= rx_pins_low ? 1'b0 : COL_IN;
         end
      end
   end

   // ************************************************************
   // pll status and reference strap
   // ************************************************************
   reg strap_done;

   always @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         RX_PLL_LOCK_LOST_LATCHED_OUT <= 1'b0;
         strap_done <= 1'b0;
         REF_FREQ_SEL_OUT <= 2'h0;
         REF_FREQ_VALID_OUT <= 1'b0;
         PHASE_CLK_ENABLE_OUT <= 1'b0;
      end
      else
      begin
         // a new loss of lock wins over a clear in the same cycle
         RX_PLL_LOCK_LOST_LATCHED_OUT <= (RX_PLL_LOCK_LOST_LATCHED_OUT & ~LOCK_LOST_CLEAR_IN)
                                         | RX_PLL_LOCK_LOST_IN;
         // straps are still held by the board at the first edge after release
         if (!strap_done)
         begin
            REF_FREQ_SEL_OUT <= REF_STRAP_IN;
            REF_FREQ_VALID_OUT <= 1'b1;
            strap_done <= 1'b1;
         end
         // the eight-phase clock is offered once the reference is known
         PHASE_CLK_ENABLE_OUT <= strap_done;
      end
   end

   // ************************************************************
   // gpio clock outputs
   // ************************************************************
   wire link_down;

   assign link_down = ~AN_LINK_GOOD_IN;

   genvar g;
   generate
      for (g = 0; g < `CPLC_NUM_GPIO; g = g + 1)
      begin : gpio_clk
         wire [1:0] src;
         wire is_recovered;
         wire squelch;

         assign src = GPIO_CLK_SRC_IN[2*g+1:2*g];
         assign is_recovered = (src == `CPLC_GPIO_REC_25) | (src == `CPLC_GPIO_REC_125);
         assign squelch = RECOVERED_CLOCK_SQUELCH_ENABLE_IN & link_down & is_recovered;

         cplc_gpio_clk u_gpio
         (
            .clk_in(CLK_IN),
            .rst_n_in(RST_N_IN),
            .src_sel_in(src),
            .squelch_in(squelch),
            .ref_125_in(TX_PLL_125_LEVEL_IN),
            .rec_25_in(RX_PLL_25_LEVEL_IN),
            .rec_125_in(RX_PLL_125_LEVEL_IN),
            .clk_out(GPIO_CLK_OUT[g])
         );
      end
   endgenerate

endmodule
`default_nettype wire

// ===== logic/cplc_top_unused_guard_none.v
/* holds no logic. assumes nothing of its surroundings. */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== sim/cplc_top_sva.sv
/* assertions on the ports of the clock path and loopback controller.
   assumes one clock domain and binding into cplc_top. */
`timescale 1ns/1ps
`default_nettype none
`include "cplc_map.vh"
module cplc_top_sva
(
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic DIAG_LOOP_ENABLE_IN,
   input wire logic DIAG_LOOP_DRIVE_OUT_IN,
   input wire logic TERMINAL_LOOP_ENABLE_IN,
   input wire logic TERMINAL_LOOP_DRIVE_OUT_IN,
   input wire logic REMOTE_LOOP_ENABLE_IN,
   input wire logic REMOTE_LOOP_DRIVE_OUT_IN,
   input wire logic COLLISION_TEST_ENABLE_IN,
   input wire logic RX_PLL_LOCK_LOST_IN,
   input wire logic LOCK_LOST_CLEAR_IN,
   input wire logic CLOCKS_GATED_OUT,
   input wire logic [2:0] TX_BUF_CLK_SRC_OUT,
   input wire logic [2:0] RX_PCS_CLK_SRC_OUT,
   input wire logic [1:0] RX_PCS_CLK_RATE_OUT,
   input wire logic RX_DEC_FROM_ENCODER_OUT,
   input wire logic CDR_FROM_TX_DRIVER_OUT,
   input wire logic TX_DATA_FROM_RX_OUT,
   input wire logic SERIAL_TX_PAIR_OE_OUT,
   input wire logic RX_PLL_LOCK_LOST_LATCHED_OUT,
   input wire logic [7:0] RXD_OUT,
   input wire logic RX_DV_OUT,
   input wire logic RX_ER_OUT,
   input wire logic CRS_OUT,
   input wire logic COL_OUT
);
// ************************************************************
// properties
// ************************************************************
default clocking cb @(posedge CLK_IN); endclocking
default disable iff (!RST_N_IN);
// gated for the whole gap so no runt edge reaches a multiplexer
sequence s_gap;
   CLOCKS_GATED_OUT [*5];
endsequence
property p_gap;
   $rose(CLOCKS_GATED_OUT) |-> s_gap;
endproperty
a_gap: assert property (p_gap)
   else $error("selection gap shorter than five cycles");
property p_gated_zero;
   CLOCKS_GATED_OUT |-> TX_BUF_CLK_SRC_OUT == 3'h0 && RX_PCS_CLK_SRC_OUT == 3'h0;
endproperty
a_gated_zero: assert property (p_gated_zero)
   else $error("selection not parked while gated");
property p_pcs_rate;
   !CLOCKS_GATED_OUT |-> RX_PCS_CLK_RATE_OUT == `CPLC_RATE_62M5;
endproperty
a_pcs_rate: assert property (p_pcs_rate)
   else $error("receive pcs clock not at 62.5");
property p_lock_set;
   RX_PLL_LOCK_LOST_IN |=> RX_PLL_LOCK_LOST_LATCHED_OUT;
endproperty
a_lock_set: assert property (p_lock_set)
   else $error("lock loss not latched");
property p_lock_hold;
   RX_PLL_LOCK_LOST_LATCHED_OUT && !LOCK_LOST_CLEAR_IN |=> RX_PLL_LOCK_LOST_LATCHED_OUT;
endproperty
a_lock_hold: assert property (p_lock_hold)
   else $error("lock loss latch dropped without clear");
property p_dec;
   $past(RST_N_IN) |-> RX_DEC_FROM_ENCODER_OUT == $past(DIAG_LOOP_ENABLE_IN);
endproperty
a_dec: assert property (p_dec)
   else $error("decoder source does not follow diagnostic loop");
property p_cdr;
   TERMINAL_LOOP_ENABLE_IN |=> CDR_FROM_TX_DRIVER_OUT;
endproperty
a_cdr: assert property (p_cdr)
   else $error("recovery not fed from driver");
property p_txrx;
   REMOTE_LOOP_ENABLE_IN |=> TX_DATA_FROM_RX_OUT;
endproperty
a_txrx: assert property (p_txrx)
   else $error("transmit not fed from receive");
property p_oe_off;
   (DIAG_LOOP_ENABLE_IN && !DIAG_LOOP_DRIVE_OUT_IN) || (TERMINAL_LOOP_ENABLE_IN && !TERMINAL_LOOP_DRIVE_OUT_IN)
      |=> !SERIAL_TX_PAIR_OE_OUT;
endproperty
a_oe_off: assert property (p_oe_off)
   else $error("serial driver not released");
property p_col;
   DIAG_LOOP_ENABLE_IN && !COLLISION_TEST_ENABLE_IN |=> !COL_OUT;
endproperty
a_col: assert property (p_col)
   else $error("collision raised in diagnostic loop");
property p_rx_low;
   REMOTE_LOOP_ENABLE_IN && !REMOTE_LOOP_DRIVE_OUT_IN && !DIAG_LOOP_ENABLE_IN
      |=> RXD_OUT == 8'h00 && !RX_DV_OUT && !RX_ER_OUT && !CRS_OUT && !COL_OUT;
endproperty
a_rx_low: assert property (p_rx_low)
   else $error("receive pins not low in remote loop");
endmodule
bind cplc_top cplc_top_sva chk (.*);
`default_nettype wire

// ===== sim/cplc_mac_model.sv
/* mac on the parallel side: raises transmit enable on command and keeps the
   last receive byte seen with data valid. assumes the system clock. */
`timescale 1ns/1ps
`default_nettype none
module cplc_mac_model
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] rxd_in,
   input wire logic rx_dv_in,
   input wire logic send_in,
   output logic tx_en_out,
   output logic [7:0] last_rx_out
);
always @(posedge clk_in or negedge rst_n_in)
begin
   if (!rst_n_in)
   begin
      tx_en_out <= 1'b0;
      last_rx_out <= 8'h00;
   end
   else
   begin
      tx_en_out <= send_in;
      if (rx_dv_in)
      begin
         last_rx_out <= rxd_in;
      end
   end
end
endmodule
`default_nettype wire

// ===== sim/tb_clock_path_and_loopback_ctrl.sv
/* self-checking bench for the clock path and loopback controller.
   assumes cplc_top with its bound checker and the mac model. */
`timescale 1ns/1ps
`default_nettype none
`include "cplc_map.vh"
module tb_clock_path_and_loopback_ctrl;
reg clk, rst_n, dce, dg, dgo, tm, tmo, rm, rmo, ct, tce, lost, clr, lg, sqe;
reg l125t, l25r, l125r, rdv, rer, crs, col, send;
reg [1:0] mode, speed, strap;
reg [7:0] gsrc, rxd;
wire [24:0] sel;
wire gated, dec, cdr, txrx, oe, tcoe, latched, rval, phen, dvo, ero, crso, colo, tx_en;
wire [1:0] rsel;
wire [3:0] gpio;
wire [7:0] rxdo, mac_rx;
integer fail_count, compares;
cplc_top dut (.CLK_IN(clk), .RST_N_IN(rst_n), .IF_MODE_IN(mode), .LINK_SPEED_IN(speed), .MII_DCE_IN(dce),
   .DIAG_LOOP_ENABLE_IN(dg), .DIAG_LOOP_DRIVE_OUT_IN(dgo), .TERMINAL_LOOP_ENABLE_IN(tm),
   .TERMINAL_LOOP_DRIVE_OUT_IN(tmo), .REMOTE_LOOP_ENABLE_IN(rm), .REMOTE_LOOP_DRIVE_OUT_IN(rmo),
   .COLLISION_TEST_ENABLE_IN(ct), .SERIAL_TX_CLOCK_ENABLE_IN(tce), .RX_PLL_LOCK_LOST_IN(lost),
   .LOCK_LOST_CLEAR_IN(clr), .REF_STRAP_IN(strap), .AN_LINK_GOOD_IN(lg), .RECOVERED_CLOCK_SQUELCH_ENABLE_IN(sqe),
   .GPIO_CLK_SRC_IN(gsrc), .TX_PLL_125_LEVEL_IN(l125t), .RX_PLL_25_LEVEL_IN(l25r), .RX_PLL_125_LEVEL_IN(l125r),
   .RX_DATA_IN(rxd), .RX_DV_IN(rdv), .RX_ER_IN(rer), .CRS_IN(crs), .COL_IN(col), .TX_EN_IN(tx_en),
   .TX_BUF_CLK_SRC_OUT(sel[24:22]), .TX_BUF_CLK_RATE_OUT(sel[21:20]), .TXCLK_DRV_SRC_OUT(sel[19:17]),
   .TXCLK_DRV_RATE_OUT(sel[16:15]), .RX_PCS_CLK_SRC_OUT(sel[14:12]), .RX_PCS_CLK_RATE_OUT(sel[11:10]),
   .RX_BUF_CLK_SRC_OUT(sel[9:7]), .RX_BUF_CLK_RATE_OUT(sel[6:5]), .RXCLK_DRV_SRC_OUT(sel[4:2]),
   .RXCLK_DRV_RATE_OUT(sel[1:0]), .CLOCKS_GATED_OUT(gated), .RX_DEC_FROM_ENCODER_OUT(dec),
   .CDR_FROM_TX_DRIVER_OUT(cdr), .TX_DATA_FROM_RX_OUT(txrx), .SERIAL_TX_PAIR_OE_OUT(oe),
   .SERIAL_TX_CLOCK_OUT_EN_OUT(tcoe), .RX_PLL_LOCK_LOST_LATCHED_OUT(latched), .REF_FREQ_SEL_OUT(rsel),
   .REF_FREQ_VALID_OUT(rval), .PHASE_CLK_ENABLE_OUT(phen), .GPIO_CLK_OUT(gpio), .RXD_OUT(rxdo),
   .RX_DV_OUT(dvo), .RX_ER_OUT(ero), .CRS_OUT(crso), .COL_OUT(colo));
cplc_mac_model mac (.clk_in(clk), .rst_n_in(rst_n), .rxd_in(rxdo), .rx_dv_in(dvo), .send_in(send),
   .tx_en_out(tx_en), .last_rx_out(mac_rx));
// ************************************************************
// clock, sampled clock levels, helpers
// ************************************************************
always #25 clk = ~clk;
// recovered 25 toggles at half the rate so a wrong source shows
always @(posedge clk)
begin
   l125t <= ~l125t;
   l125r <= ~l125r;
   l25r <= l25r ^ l125t;
end
task chk(input [31:0] seen, input [31:0] exp);
   begin
      compares = compares + 1;
      if (seen !== exp)
      begin
         fail_count = fail_count + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
endtask
task end_of_test;
   begin
      if (fail_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
endtask
// wait n edges, then sample where outputs have settled
task tick(input integer n);
   begin
      repeat (n) @(posedge clk);
      @(negedge clk);
   end
endtask
function [24:0] exp_sel(input [1:0] m, input [1:0] sp, input dc, input d, input r);
   reg [1:0] rt;
   reg dte;
   reg dcm;
   reg [2:0] rx;
   begin
      rt = (m == `CPLC_MODE_GMII || sp == `CPLC_SPEED_1000) ? `CPLC_RATE_125M
         : (sp == `CPLC_SPEED_100) ? `CPLC_RATE_25M : `CPLC_RATE_2M5;
      dte = (m == `CPLC_MODE_MII) && !dc;
      dcm = (m == `CPLC_MODE_MII) && dc;
      rx = d ? `CPLC_SRC_TX_PLL : `CPLC_SRC_RX_PLL;
      exp_sel[24:20] = {r ? (dte ? `CPLC_SRC_RXCLK_PIN : `CPLC_SRC_RX_PLL)
         : (dcm ? `CPLC_SRC_TX_PLL : dte ? `CPLC_SRC_TXCLK_PIN : `CPLC_SRC_GTX), rt};
      exp_sel[19:15] = dcm ? {`CPLC_SRC_TX_PLL, rt} : 5'h00;
      exp_sel[14:10] = {rx, `CPLC_RATE_62M5};
      exp_sel[9:5] = {dte ? (d ? `CPLC_SRC_TXCLK_PIN : `CPLC_SRC_RXCLK_PIN) : rx, rt};
      exp_sel[4:0] = dte ? 5'h00 : {rx, rt};
   end
endfunction
// ************************************************************
// scenarios
// ************************************************************
task do_reset(input [1:0] s);
   begin
      @(posedge clk);
      rst_n <= 1'b0;
      strap <= s;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      tick(3);
      chk({rsel, rval, phen, latched}, {s, 3'h6});
   end
endtask
// every mode, speed, dce setting and the diagnostic and remote loopbacks against the selection tables
task t_paths;
   integer i;
   begin
      for (i = 0; i < 54; i = i + 1)
      begin
         @(posedge clk);
         mode <= 2'(i % 3);
         speed <= 2'((i / 3) % 3);
         dce <= 1'((i / 9) % 2);
         dg <= (i / 18 == 1);
         rm <= (i / 18 == 2);
         rmo <= 1'b1;
         tick(8);
         chk(sel, exp_sel(mode, speed, dce, dg, rm));
         chk({gated, dec, txrx}, {1'b0, dg, rm});
      end
      @(posedge clk);
      rm <= 1'b0;
      dg <= 1'b0;
   end
endtask
task t_drive;
   integer i;
   begin
      for (i = 0; i < 16; i = i + 1)
      begin
         @(posedge clk);
         {tmo, tm, dgo, dg} <= 4'(i);
         tce <= i[1];
         tick(2);
         chk(oe, !((i[0] && !i[1]) || (i[2] && !i[3])));
         chk({tcoe, cdr}, {i[1], i[2]});
      end
      @(posedge clk);
      {tmo, tm, dgo, dg} <= 4'h0;
   end
endtask
task t_remote;
   begin
      @(posedge clk);
      {rxd, rdv, rer, crs, col} <= 12'hA5F;
      rm <= 1'b1;
      rmo <= 1'b0;
      tick(2);
      chk({rxdo, dvo, ero, crso, colo}, 12'h000);
      @(posedge clk);
      rmo <= 1'b1;
      tick(3);
      chk({rxdo, dvo, ero, crso, colo}, 12'hA5F);
      chk(mac_rx, 8'hA5);
      @(posedge clk);
      rm <= 1'b0;
   end
endtask
task t_col;
   begin
      @(posedge clk);
      dg <= 1'b1;
      send <= 1'b1;
      tick(3);
      chk(colo, 1'h0);
      @(posedge clk);
      ct <= 1'b1;
      tick(2);
      chk(colo, 1'h1);
      @(posedge clk);
      send <= 1'b0;
      tick(3);
      chk(colo, 1'h0);
      @(posedge clk);
      {dg, ct} <= 2'h0;
      tick(2);
      chk(colo, 1'h1);
   end
endtask
task t_lock;
   begin
      @(posedge clk);
      lost <= 1'b1;
      @(posedge clk);
      lost <= 1'b0;
      tick(3);
      chk(latched, 1'h1);
      @(posedge clk);
      {clr, lost} <= 2'h3;
      tick(2);
      chk(latched, 1'h1);
      @(posedge clk);
      lost <= 1'b0;
      tick(2);
      chk(latched, 1'h0);
      @(posedge clk);
      clr <= 1'b0;
   end
endtask
task t_gpio;
   reg [2:0] s;
   integer i;
   begin
      @(posedge clk);
      gsrc <= {`CPLC_GPIO_REC_125, `CPLC_GPIO_REC_25, `CPLC_GPIO_REF_125, `CPLC_GPIO_OFF};
      {lg, sqe} <= 2'h3;
      tick(8);
      for (i = 0; i < 4; i = i + 1)
      begin
         s = {l125r, l25r, l125t};
         tick(1);
         chk(gpio, {s, 1'b0});
      end
      @(posedge clk);
      lg <= 1'b0;
      tick(8);
      for (i = 0; i < 4; i = i + 1)
      begin
         s = {2'h0, l125t};
         tick(1);
         chk(gpio, {s, 1'b0});
      end
   end
endtask
initial
begin
   clk = 1'b0;
   rst_n = 1'b0;
   {dce, dg, dgo, tm, tmo, rm, rmo, ct, tce, lost, clr, lg, sqe} = 13'h0000;
   {l125t, l25r, l125r, rdv, rer, crs, col, send} = 8'h00;
   {mode, speed, strap, gsrc, rxd} = 22'h000000;
   fail_count = 0;
   compares = 0;
   do_reset(2'h2);
   t_paths;
   t_drive;
   t_remote;
   t_col;
   t_lock;
   t_gpio;
   do_reset(2'h1);
   t_lock;
   end_of_test;
end
// a hang counts as a failure
initial
begin
   repeat (20000) @(posedge clk);
   fail_count = fail_count + 1;
   end_of_test;
end
endmodule
`default_nettype wire
